// file: shared/or_move_cfg.svh
`ifndef OR_MOVE_CFG_SVH
`define OR_MOVE_CFG_SVH

// word and field layout of one instruction
`define INSTR_W 14
`define ADDR_W 7
`define DATA_W 8
`define OPC_HI 13
`define OPC6_LO 8
`define OPC4_LO 10
`define OPC7_LO 7
`define DEST_BIT 7
`define NOP_ZERO_HI 4

// opcode patterns
`define OPC6_OR_ACCUM 6'h04
`define OPC6_COPY_REG 6'h08
`define OPC4_LOAD_LIT 4'hc
`define OPC7_STORE 7'h01
`define OPC7_NOP 7'h00

// reset values
`define ACCUM_RST 8'h00
`define NULL_FLAG_RST 1'b0

// clocks taken per instruction: issue plus execute
`define CLOCKS_PER_INSTR 2

`endif

// file: shared/or_move_pkg.sv
package or_move_pkg;

  // decoded operation of the group
  typedef enum logic [2:0] {
    OP_NONE = 3'b000,
    OP_OR_ACCUM = 3'b001,
    OP_COPY_REG = 3'b010,
    OP_LOAD_LIT = 3'b011,
    OP_STORE_ACCUM = 3'b100,
    OP_OTHER = 3'b101
  } op_t;

  typedef enum logic [0:0] {
    ST_ISSUE = 1'b0,
    ST_EXEC = 1'b1
  } phase_t;

  // one file-register write
  typedef struct packed {
    logic en;
    logic [6:0] addr;
    logic [7:0] data;
  } reg_write_t;

  // processor state seen by the outside
  typedef struct packed {
    logic [7:0] accum;
    logic result_null_flag;
  } core_state_t;

endpackage

// file: logic/reg_file_mem.sv
`timescale 1ns/10ps
module reg_file_mem #(
  parameter int ADDR_W = 7,
  parameter int DATA_W = 8
) (
  input wire logic clock,
  input wire logic [ADDR_W-1:0] rd_addr,
  output logic [DATA_W-1:0] rd_data,
  input wire logic wr_en,
  input wire logic [ADDR_W-1:0] wr_addr,
  input wire logic [DATA_W-1:0] wr_data
);

  logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];

  // synchronous write, registered read
  always_ff @(posedge clock) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end

endmodule

// file: logic/or_move_instr_exec.sv
// Overview of operation
// - 00 0100 d f decodes as or_accum_into_reg; OR accumulator with f, set null flag.
// - destination bit 0 puts the result in the accumulator, register untouched.
// - destination bit 1 writes the result back into the addressed register.
// - 00 1000 d f decodes as copy_reg; register value moves unchanged to destination.
// - copy_reg sets the null flag from the moved value, also when copied in place.
// - 11 00xx k decodes as load_literal; literal to accumulator, flags unchanged.
// - 00 0000 1 f decodes as store_accum; accumulator to register, flags unchanged.
`timescale 1ns/10ps
`include "or_move_cfg.svh"
module or_move_instr_exec #(
  parameter int ADDR_W = `ADDR_W,
  parameter int DATA_W = `DATA_W
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic instr_valid,
  input wire logic [`INSTR_W-1:0] instr_word,
  output logic instr_ready_q,
  output logic instr_done_q,
  output logic unsupported_q,
  output or_move_pkg::core_state_t core_q,
  output or_move_pkg::reg_write_t wb_q
);
  import or_move_pkg::*;

  // classify one instruction word of this group
  function automatic op_t decode(input logic [`INSTR_W-1:0] w);
    op_t op;
    op = OP_OTHER;
    if (w[`OPC_HI:`OPC6_LO] == `OPC6_OR_ACCUM) begin
      op = OP_OR_ACCUM;
    end else if (w[`OPC_HI:`OPC6_LO] == `OPC6_COPY_REG) begin
      op = OP_COPY_REG;
    end else if (w[`OPC_HI:`OPC4_LO] == `OPC4_LOAD_LIT) begin
      op = OP_LOAD_LIT;
    end else if (w[`OPC_HI:`OPC7_LO] == `OPC7_STORE) begin
      op = OP_STORE_ACCUM;
    end else if (w[`OPC_HI:`OPC7_LO] == `OPC7_NOP && w[`NOP_ZERO_HI:0] == 5'h00) begin
      op = OP_NONE;
    end
    return op;
  endfunction

  phase_t phase_q, phase_d;
  logic [`INSTR_W-1:0] instr_q, instr_d;
  logic [DATA_W-1:0] accum_q, accum_d;
  logic null_q, null_d;
  logic ready_d, done_d, unsup_d;
  reg_write_t wb_d;
  logic [DATA_W-1:0] rd_data;
  logic [ADDR_W-1:0] rd_addr;
  op_t exec_op;
  logic exec_dest;
  logic [ADDR_W-1:0] exec_addr;
  logic [DATA_W-1:0] result;

  // fields of the held instruction; read address from the offered word
  assign exec_op = decode(instr_q);
  assign exec_dest = instr_q[`DEST_BIT];
  assign exec_addr = instr_q[ADDR_W-1:0];
  assign rd_addr = instr_word[ADDR_W-1:0];

  // file registers, read while the instruction is taken
  reg_file_mem #(
    .ADDR_W(ADDR_W),
    .DATA_W(DATA_W)
  ) u_mem (
    .clock(clock),
    .rd_addr(rd_addr),
    .rd_data(rd_data),
    .wr_en(wb_d.en),
    .wr_addr(wb_d.addr),
    .wr_data(wb_d.data)
  );

  // operation result ahead of the destination choice
  always_comb begin
    unique case (exec_op)
      OP_OR_ACCUM: result = accum_q | rd_data;
      OP_COPY_REG: result = rd_data;
      default: result = accum_q;
    endcase
  end

  // issue and execute sequencing with the state updates
  always_comb begin
    phase_d = phase_q;
    instr_d = instr_q;
    accum_d = accum_q;
    null_d = null_q;
    ready_d = 1'b0;
    done_d = 1'b0;
    unsup_d = 1'b0;
    wb_d = '0;
    unique case (phase_q)
      ST_ISSUE: begin
        if (instr_valid && instr_ready_q) begin
          instr_d = instr_word;
          phase_d = ST_EXEC;
        end else begin
          ready_d = 1'b1;
        end
      end
      ST_EXEC: begin
        phase_d = ST_ISSUE;
        ready_d = 1'b1;
        done_d = 1'b1;
        unique case (exec_op)
          OP_OR_ACCUM, OP_COPY_REG: begin
            null_d = (result == '0);
            if (exec_dest) begin
              wb_d.en = 1'b1;
              wb_d.addr = exec_addr;
              wb_d.data = result;
            end else begin
              accum_d = result;
            end
          end
          OP_LOAD_LIT: begin
            accum_d = instr_q[DATA_W-1:0];
          end
          OP_STORE_ACCUM: begin
            wb_d.en = 1'b1;
            wb_d.addr = exec_addr;
            wb_d.data = accum_q;
          end
          OP_NONE: begin
            accum_d = accum_q;
          end
          OP_OTHER: begin
            unsup_d = 1'b1;
          end
        endcase
      end
    endcase
  end

  // registers of the sequencer and the processor state
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      phase_q <= ST_ISSUE;
      instr_q <= '0;
      accum_q <= `ACCUM_RST;
      null_q <= `NULL_FLAG_RST;
      instr_ready_q <= 1'b0;
      instr_done_q <= 1'b0;
      unsupported_q <= 1'b0;
      core_q <= '0;
      wb_q <= '0;
    end else begin
      phase_q <= phase_d;
      instr_q <= instr_d;
      accum_q <= accum_d;
      null_q <= null_d;
      instr_ready_q <= ready_d;
      instr_done_q <= done_d;
      unsupported_q <= unsup_d;
      core_q <= '{accum: accum_d, result_null_flag: null_d};
      wb_q <= wb_d;
    end
  end

  // checks on the execute phase
  wire exec_now = (phase_q == ST_EXEC);

  a_or_null_flag: assert property (@(posedge clock) disable iff (!resetn)
    exec_now && exec_op == OP_OR_ACCUM |=>
      null_q == (($past(accum_q) | $past(rd_data)) == '0))
    else $error("or result null flag wrong");

  a_dest_zero_accum: assert property (@(posedge clock) disable iff (!resetn)
    exec_now && exec_op inside {OP_OR_ACCUM, OP_COPY_REG} && !exec_dest |=>
      accum_q == $past(result) && !wb_q.en)
    else $error("dest 0 must load accumulator only");

  a_dest_one_write: assert property (@(posedge clock) disable iff (!resetn)
    exec_now && exec_op inside {OP_OR_ACCUM, OP_COPY_REG} && exec_dest |=>
      wb_q.en && wb_q.addr == $past(exec_addr) && $stable(accum_q))
    else $error("dest 1 must write the register");

  a_copy_unchanged: assert property (@(posedge clock) disable iff (!resetn)
    exec_now && exec_op == OP_COPY_REG && exec_dest |=> wb_q.data == $past(rd_data))
    else $error("copy altered the value");

  a_copy_null_flag: assert property (@(posedge clock) disable iff (!resetn)
    exec_now && exec_op == OP_COPY_REG |=> null_q == ($past(rd_data) == '0))
    else $error("copy null flag wrong");

  a_literal_load: assert property (@(posedge clock) disable iff (!resetn)
    exec_now && exec_op == OP_LOAD_LIT |=>
      accum_q == $past(instr_q[7:0]) && $stable(null_q))
    else $error("literal load wrong");

  a_store_accum: assert property (@(posedge clock) disable iff (!resetn)
    exec_now && exec_op == OP_STORE_ACCUM |=>
      wb_q.en && wb_q.data == $past(accum_q) && $stable(null_q))
    else $error("store wrong");

  a_nop_quiet: assert property (@(posedge clock) disable iff (!resetn)
    exec_now && exec_op == OP_NONE |=> $stable(accum_q) && $stable(null_q) && !wb_q.en)
    else $error("no-op changed state");

  a_one_exec_cycle: assert property (@(posedge clock) disable iff (!resetn)
    phase_q == ST_ISSUE && instr_valid && instr_ready_q |=> exec_now ##1 instr_done_q)
    else $error("instruction not done in time");

  c_or_to_reg: cover property (@(posedge clock) disable iff (!resetn)
    exec_now && exec_op == OP_OR_ACCUM && exec_dest);
  c_copy_in_place_zero: cover property (@(posedge clock) disable iff (!resetn)
    exec_now && exec_op == OP_COPY_REG && exec_dest && rd_data == '0);
  c_store_then_load: cover property (@(posedge clock) disable iff (!resetn)
    exec_now && exec_op == OP_STORE_ACCUM ##2 exec_now && exec_op == OP_LOAD_LIT);

endmodule

// file: verification/test_or_move_instr_exec.sv
`timescale 1ns/10ps
`include "or_move_cfg.svh"
module test_or_move_instr_exec;
  import or_move_pkg::*;
  typedef struct packed {
    logic [13:0] word;
    core_state_t st;
    reg_write_t wb;
    logic unsup;
  } row_t;
  localparam reg_write_t NW = '{1'b0, 7'h00, 8'h00};
  // full-rate run: clear accumulator, store it to a fresh register, copy it straight back
  localparam logic [13:0] BURST [3] = '{14'h3000, 14'h00a0, 14'h0820};
  // word, expected accumulator and flag, expected write echo, outside-group pulse
  localparam row_t ROWS [19] = '{
    '{14'h3300, '{8'h00, 1'b0}, NW, 1'b0},
    '{14'h3091, '{8'h91, 1'b0}, NW, 1'b0},
    '{14'h3013, '{8'h13, 1'b0}, NW, 1'b0},
    '{14'h0085, '{8'h13, 1'b0}, '{1'b1, 7'h05, 8'h13}, 1'b0},
    '{14'h3091, '{8'h91, 1'b0}, NW, 1'b0},
    '{14'h0405, '{8'h93, 1'b0}, NW, 1'b0},
    '{14'h0485, '{8'h93, 1'b0}, '{1'b1, 7'h05, 8'h93}, 1'b0},
    '{14'h3000, '{8'h00, 1'b0}, NW, 1'b0},
    '{14'h00ff, '{8'h00, 1'b0}, '{1'b1, 7'h7f, 8'h00}, 1'b0},
    '{14'h305a, '{8'h5a, 1'b0}, NW, 1'b0},
    '{14'h08ff, '{8'h5a, 1'b1}, '{1'b1, 7'h7f, 8'h00}, 1'b0},
    '{14'h32ff, '{8'hff, 1'b1}, NW, 1'b0},
    '{14'h047f, '{8'hff, 1'b0}, NW, 1'b0},
    '{14'h087f, '{8'h00, 1'b1}, NW, 1'b0},
    '{14'h0090, '{8'h00, 1'b1}, '{1'b1, 7'h10, 8'h00}, 1'b0},
    '{14'h0060, '{8'h00, 1'b1}, NW, 1'b0},
    '{14'h0009, '{8'h00, 1'b1}, NW, 1'b1},
    '{14'h0000, '{8'h00, 1'b1}, NW, 1'b0},
    '{14'h3155, '{8'h55, 1'b1}, NW, 1'b0}
  };
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic instr_valid = 1'b0;
  logic [`INSTR_W-1:0] instr_word = 14'h0000;
  logic instr_ready_q;
  logic instr_done_q;
  logic unsupported_q;
  core_state_t core_q;
  reg_write_t wb_q;
  core_state_t st;
  reg_write_t wb;
  logic un;
  int n_fail = 0;
  int num_checks = 0;

  // 25 MHz instruction clock
  always #20 clock = ~clock;

  or_move_instr_exec dut_u (
    .clock(clock),
    .resetn(resetn),
    .instr_valid(instr_valid),
    .instr_word(instr_word),
    .instr_ready_q(instr_ready_q),
    .instr_done_q(instr_done_q),
    .unsupported_q(unsupported_q),
    .core_q(core_q),
    .wb_q(wb_q)
  );

  // counts, verdict and stop
  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic miss(input logic [15:0] got, input logic [15:0] exp);
    n_fail++;
    $display("unexpected at %0t got %h exp %h", $time, got, exp);
  endtask

  task automatic chk_b(input logic got, input logic exp);
    num_checks++;
    if (got !== exp) miss({15'h0000, got}, {15'h0000, exp});
  endtask

  task automatic chk_st(input core_state_t got, input core_state_t exp);
    num_checks++;
    if (got !== exp) miss({7'h00, got}, {7'h00, exp});
  endtask

  // write echo: address and data only matter when a write is expected
  task automatic chk_wb(input reg_write_t got, input reg_write_t exp);
    num_checks++;
    if (exp.en ? got !== exp : got.en !== 1'b0) miss(got, exp);
  endtask

  // offer one word, hold it until taken, capture the answer
  task automatic issue(input logic [13:0] w);
    int i;
    int lat;
    @(posedge clock);
    instr_valid <= 1'b1;
    instr_word <= w;
    for (i = 0; i < 9; i++) begin
      @(posedge clock);
      if (instr_ready_q === 1'b1) break;
    end
    instr_valid <= 1'b0;
    lat = 0;
    do begin
      @(negedge clock);
      lat++;
    end while (instr_done_q !== 1'b1 && lat < 8);
    if (i == 9 || lat == 8) begin
      n_fail++;
      end_sim();
    end
    chk_b(lat == `CLOCKS_PER_INSTR, 1'b1);
    st = core_q;
    wb = wb_q;
    un = unsupported_q;
    @(negedge clock);
    chk_b(instr_done_q | wb_q.en | unsupported_q, 1'b0);
  endtask

  // offer words back to back; the copy reads a register written by the instruction before
  task automatic burst();
    int n;
    int t;
    int dones;
    n = 0;
    t = 0;
    dones = 0;
    @(posedge clock);
    instr_valid <= 1'b1;
    instr_word <= BURST[0];
    while (n < 3 && t < 12) begin
      @(posedge clock);
      t++;
      if (instr_done_q === 1'b1) dones++;
      if (instr_ready_q === 1'b1) begin
        n++;
        if (n < 3) instr_word <= BURST[n];
        else instr_valid <= 1'b0;
      end
    end
    if (n < 3) begin
      n_fail++;
      end_sim();
    end
    repeat (2) @(negedge clock);
    if (instr_done_q === 1'b1) dones++;
    chk_b(t == 2 * `CLOCKS_PER_INSTR + 1, 1'b1);
    chk_b(dones == 3, 1'b1);
    chk_st(core_q, '{8'h00, 1'b1});
  endtask

  // table run, then a reset with no instruction in flight, then the back-to-back burst
  initial begin
    repeat (16) @(posedge clock);
    chk_b(instr_ready_q, 1'b0);
    chk_st(core_q, '{8'h00, 1'b0});
    resetn <= 1'b1;
    for (int k = 0; k < $size(ROWS); k++) begin
      issue(ROWS[k].word);
      chk_st(st, ROWS[k].st);
      chk_wb(wb, ROWS[k].wb);
      chk_b(un, ROWS[k].unsup);
      $display("row %0d done", k);
    end
    @(posedge clock);
    resetn <= 1'b0;
    @(negedge clock);
    chk_st(core_q, '{8'h00, 1'b0});
    chk_b(instr_ready_q, 1'b0);
    repeat (2) @(posedge clock);
    resetn <= 1'b1;
    // file register kept its value across reset
    issue(14'h0805);
    chk_st(st, '{8'h93, 1'b0});
    chk_wb(wb, NW);
    $display("reset test done");
    burst();
    $display("burst test done");
    end_sim();
  end
endmodule
